// ===== rtl/ifb_pkg.sv
package ifb_pkg;

   // Register offsets as seen by the management bus engine.
   localparam logic [7:0] UNLOCK_OFFSET = 8'h08;
   localparam logic [7:0] POINTER_OFFSET = 8'h09;
   localparam logic [7:0] COMMAND_OFFSET = 8'h0A;

   // Unlock pattern and register reset values.
   localparam logic [7:0] UNLOCK_PATTERN = 8'hBB;
   localparam logic [7:0] UNLOCK_RESET = 8'h00;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [7:0] COMMAND_RESET = 8'h00;
   localparam logic [7:0] READ_UNMAPPED = 8'h00;

   // Command register field positions.
   localparam int CMD_WRITE_POS = 7;
   localparam int CMD_READ_POS = 6;
   localparam int CMD_VALUE_POS = 1;

   // Feature bit store geometry.
   localparam int STORE_BITS = 256;
   localparam logic [STORE_BITS-1:0] STORE_RESET = 256'h0;

   // Feature field positions.
   localparam int DRIVE_LSB = 140;
   localparam int DRIVE_W = 4;
   localparam int NUM_OUTPUTS = 19;
   localparam int DRIVE_ALL_W = DRIVE_W * NUM_OUTPUTS;
   localparam int REF_LOAD_LSB = 216;
   localparam int FB_LOAD_LSB = 219;
   localparam int LOAD_W = 3;
   localparam int BYPASS_POS = 222;

   // Field reset values.
   localparam logic [LOAD_W-1:0] LOAD_RESET = 3'h0;
   localparam logic BYPASS_RESET = 1'b0;

   // Bypass path delays in picoseconds, long for 0 and short for 1.
   localparam int BYPASS_LONG_PS = 2500;
   localparam int BYPASS_SHORT_PS = 900;

   // Drive strength codes, full strength down to no drive.
   localparam logic [DRIVE_W-1:0] DRIVE_100 = 4'h0;
   localparam logic [DRIVE_W-1:0] DRIVE_90 = 4'h1;
   localparam logic [DRIVE_W-1:0] DRIVE_80 = 4'h3;
   localparam logic [DRIVE_W-1:0] DRIVE_70 = 4'h4;
   localparam logic [DRIVE_W-1:0] DRIVE_60 = 4'h6;
   localparam logic [DRIVE_W-1:0] DRIVE_50 = 4'h7;
   localparam logic [DRIVE_W-1:0] DRIVE_40 = 4'hA;
   localparam logic [DRIVE_W-1:0] DRIVE_30 = 4'hB;
   localparam logic [DRIVE_W-1:0] DRIVE_20 = 4'hC;
   localparam logic [DRIVE_W-1:0] DRIVE_10 = 4'hE;
   localparam logic [DRIVE_W-1:0] DRIVE_OFF = 4'hF;

endpackage

// ===== rtl/ifb_store_if.sv
`timescale 1ns/10ps
`default_nettype none

// Carries bit writes, the bit lookup and the stored image between control and store.
interface ifb_store_if;
   logic wr_en;
   logic [7:0] wr_index;
   logic wr_value;
   logic [7:0] rd_index;
   logic rd_value;
   logic [ifb_pkg::STORE_BITS-1:0] bits;

   modport ctrl (
      output wr_en,
      output wr_index,
      output wr_value,
      output rd_index,
      input rd_value,
      input bits
   );

   modport store (
      input wr_en,
      input wr_index,
      input wr_value,
      input rd_index,
      output rd_value,
      output bits
   );
endinterface

`default_nettype wire

// ===== rtl/ifb_bit_store.sv
`timescale 1ns/10ps
`default_nettype none

module ifb_bit_store (
   input wire logic clock_i,
   input wire logic rst_b_i,
   ifb_store_if.store port
);

   logic [ifb_pkg::STORE_BITS-1:0] bits_ff;

   // One bit changes per write; every other bit holds until rewritten or reset.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         bits_ff <= ifb_pkg::STORE_RESET;
      end else if (port.wr_en) begin
         bits_ff[port.wr_index] <= port.wr_value;
      end
   end

   // The lookup is combinational so the controller can register it with the read.
   assign port.rd_value = bits_ff[port.rd_index];
   assign port.bits = bits_ff;

endmodule

`default_nettype wire

// ===== rtl/ifb_feature_store.sv
// What this block does
// - Bits 218..216 select reference input load.
// - Bits 221..219 select feedback input load.
// - Bit 222 picks short bypass delay.
// - Bits 215..140 hold nineteen drive codes.
// - Each drive code steers only its output.
// - Drive codes reset to full strength.
// - Pointer register selects the feature bit.
// - Command 0x82 sets selected bit to one.
// - Command register read shows bit in 6.
// - Command 1000_00s0 stores s.
`timescale 1ns/10ps
`default_nettype none

module ifb_feature_store (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   output logic [7:0] reg_rdata_o,
   output logic [ifb_pkg::LOAD_W-1:0] ref_input_load_select_o,
   output logic [ifb_pkg::LOAD_W-1:0] feedback_input_load_select_o,
   output logic bypass_short_delay_o,
   output logic [ifb_pkg::DRIVE_ALL_W-1:0] output_drive_code_o
);

   ifb_store_if store_bus ();

   logic [7:0] unlock_ff;
   logic [7:0] pointer_ff;
   logic [7:0] command_ff;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic unlocked;
   logic wr_unlock;
   logic wr_pointer;
   logic wr_command;
   logic hit_unlock;
   logic hit_pointer;
   logic hit_command;

   // Access model, as seen from the management bus engine that drives the strobes.
   // The bank sits behind three byte registers. The unlock register gates the
   // other two: until it holds the unlock pattern, writes to the pointer and to
   // the command register fall away silently, so a stray transfer after power-up
   // cannot disturb a feature bit.
   // The pointer register names one of 256 bit positions as a plain binary
   // number. Positions outside the known fields are still stored, which keeps
   // the read-back of any position predictable for the host.
   // A command byte with its top bit set writes its value bit into the bit that
   // the pointer names, on the same edge that takes the byte. The host follows
   // with an all-zero close byte; that byte has its top bit clear and so stores
   // nothing, which means a host that skips it does no harm here.
   // A multi-bit field changes one bit per command, so a field may pass through
   // intermediate codes while the host walks its bits. The analog side must
   // tolerate those steps; nothing here holds a field back until it is whole.
   // Reading the command register returns the last command byte with bit 6
   // replaced by the bit that the pointer names. Read data is registered on the
   // read strobe, so the host takes it one cycle after the strobe, and it stands
   // until the next read.

   // One offset compare shared by the write decode and the read mux, so the two
   // can never disagree about which register an address means.
   function automatic logic offset_hit(input logic [7:0] addr, input logic [7:0] offset);
      offset_hit = (addr == offset);
   endfunction

   // Address decode; the pointer and command registers only take writes after unlocking.
   assign hit_unlock = offset_hit(reg_addr_i, ifb_pkg::UNLOCK_OFFSET);
   assign hit_pointer = offset_hit(reg_addr_i, ifb_pkg::POINTER_OFFSET);
   assign hit_command = offset_hit(reg_addr_i, ifb_pkg::COMMAND_OFFSET);
   assign unlocked = (unlock_ff == ifb_pkg::UNLOCK_PATTERN);
   assign wr_unlock = reg_wr_i && hit_unlock;
   assign wr_pointer = reg_wr_i && unlocked && hit_pointer;
   assign wr_command = reg_wr_i && unlocked && hit_command;

   // The unlock register always accepts writes so the host can lock it again.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         unlock_ff <= ifb_pkg::UNLOCK_RESET;
      end else if (wr_unlock) begin
         unlock_ff <= reg_wdata_i;
      end
   end

   // The pointer is a plain binary bit position.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pointer_ff <= ifb_pkg::POINTER_RESET;
      end else if (wr_pointer) begin
         pointer_ff <= reg_wdata_i;
      end
   end

   // Command image; closing with zero clears the write flag.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         command_ff <= ifb_pkg::COMMAND_RESET;
      end else if (wr_command) begin
         command_ff <= reg_wdata_i;
      end
   end

   // A command with its top bit set stores its value bit into the selected bit.
   // Each such write commits at once, so the close write is tolerated but not required.
   assign store_bus.wr_en = wr_command && reg_wdata_i[ifb_pkg::CMD_WRITE_POS];
   assign store_bus.wr_index = pointer_ff;
   assign store_bus.wr_value = reg_wdata_i[ifb_pkg::CMD_VALUE_POS];
   assign store_bus.rd_index = pointer_ff;

   ifb_bit_store u_store (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .port(store_bus.store)
   );

   // Read mux; the command register returns the selected feature bit in bit 6.
   always_comb begin
      nxt_rdata = ifb_pkg::READ_UNMAPPED;
      if (hit_unlock) begin
         nxt_rdata = unlock_ff;
      end else if (hit_pointer) begin
         nxt_rdata = pointer_ff;
      end else if (hit_command) begin
         nxt_rdata = command_ff;
         nxt_rdata[ifb_pkg::CMD_READ_POS] = store_bus.rd_value;
      end
   end

   // Read data is captured on the read strobe and held until the next read.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rdata_ff <= ifb_pkg::READ_UNMAPPED;
      end else if (reg_rd_i) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata_o = rdata_ff;

   // Field outputs are slices of the store flops; each slice feeds one consumer only.
   // Store reset is all zero, giving load code 000, long bypass and full drive.
   assign ref_input_load_select_o =
      store_bus.bits[ifb_pkg::REF_LOAD_LSB +: ifb_pkg::LOAD_W];
   assign feedback_input_load_select_o =
      store_bus.bits[ifb_pkg::FB_LOAD_LSB +: ifb_pkg::LOAD_W];
   assign bypass_short_delay_o = store_bus.bits[ifb_pkg::BYPASS_POS];

   // Each output takes its own four-bit slice, so a code written for one output
   // can never reach a neighbour; output n sits at bits 4n+3 down to 4n.
   // The zero reset of the store gives every output full drive.
   for (genvar n = 0; n < ifb_pkg::NUM_OUTPUTS; n++) begin : g_drive
      assign output_drive_code_o[n*ifb_pkg::DRIVE_W +: ifb_pkg::DRIVE_W] =
         store_bus.bits[ifb_pkg::DRIVE_LSB + n*ifb_pkg::DRIVE_W +: ifb_pkg::DRIVE_W];
   end

endmodule

`default_nettype wire

// ===== tb/ifb_host.sv
`timescale 1ns/10ps
`default_nettype none
module ifb_host (
   input wire logic clock_i,
   input wire logic [7:0] rdata_i,
   output logic wr_o,
   output logic rd_o,
   output logic [7:0] addr_o,
   output logic [7:0] wdata_o
);
   // The bus idles with both strobes low.
   initial {wr_o, rd_o, addr_o, wdata_o} = 18'h00000;
   // One strobe pulse, then a quiet cycle, so no strobe is set twice in one step.
   task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      {wr_o, rd_o, addr_o, wdata_o} = {w, !w, a, d};
      @(posedge clock_i);
      #1 {wr_o, rd_o} = 2'h0;
      q = rdata_i;
      @(posedge clock_i);
      #1;
   endtask
   // One feature bit per pass: pointer, command, then the closing zero.
   task automatic set_bit(input logic [7:0] p, input logic s);
      logic [7:0] q;
      xfer(1'h1, 8'h09, p, q);
      xfer(1'h1, 8'h0A, {6'h20, s, 1'h0}, q);
      xfer(1'h1, 8'h0A, 8'h00, q);
   endtask
endmodule
`default_nettype wire

// ===== tb/ifb_props.sv
`timescale 1ns/10ps
`default_nettype none
module ifb_props (
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   input wire logic [7:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic [7:0] reg_rdata_o,
   input wire logic [2:0] ref_input_load_select_o,
   input wire logic [2:0] feedback_input_load_select_o,
   input wire logic bypass_short_delay_o,
   input wire logic [75:0] output_drive_code_o
);
   // Bits 222 down to 140 as one image; sel is the bit the pointer names.
   wire logic [82:0] img = {bypass_short_delay_o, feedback_input_load_select_o,
      ref_input_load_select_o, output_drive_code_o};
   logic unl_ff;
   logic [7:0] ptr_ff;
   wire logic ra = reg_addr_i == 8'h0A;
   wire logic inr = ptr_ff >= 8'h8C && ptr_ff <= 8'hDE;
   wire logic sel = img[ptr_ff - 8'h8C];
   wire logic cmd = reg_wr_i && ra && unl_ff && reg_wdata_i[7];
   // Shadow lock and pointer; the pointer only moves while unlocked.
   always_ff @(posedge clock_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         unl_ff <= 1'h0;
         ptr_ff <= 8'h00;
      end else if (reg_wr_i && reg_addr_i == 8'h08) begin
         unl_ff <= reg_wdata_i == 8'hBB;
      end else if (reg_wr_i && reg_addr_i == 8'h09 && unl_ff) begin
         ptr_ff <= reg_wdata_i;
      end
   end
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rst_b_i);
   a_bit_write: assert property (cmd && inr |=> sel == $past(reg_wdata_i[1]))
      else $error("Stored bit wrong.");
   a_one_bit: assert property (cmd |=> $onehot0(img ^ $past(img)))
      else $error("Extra bit moved.");
   a_field_hold: assert property (!cmd |=> $stable(img)) else $error("Field moved.");
   a_lock_gate: assert property (reg_wr_i && !unl_ff |=> $stable(img))
      else $error("Locked write took.");
   a_no_store: assert property (reg_wr_i && ra && !reg_wdata_i[7] |=> $stable(img))
      else $error("Close stored.");
   a_read_bit6: assert property (reg_rd_i && ra && inr |=> reg_rdata_o[6] == $past(sel))
      else $error("Bit six wrong.");
   a_rdata_hold: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
      else $error("Read data moved.");
   a_unmapped_read: assert property (reg_rd_i && (reg_addr_i < 8'h08 || reg_addr_i > 8'h0A)
      |=> reg_rdata_o == 8'h00) else $error("Unmapped read.");
   cover property (cmd && inr);
   cover property (reg_rd_i && ra && inr);
   cover property (reg_wr_i && !unl_ff);
endmodule
bind ifb_feature_store ifb_props u_ifb_props (.*);
`default_nettype wire

// ===== tb/ifb_feature_store_test.sv
`timescale 1ns/10ps
`default_nettype none
module ifb_feature_store_test;
   logic clock_i, rst_b_i, reg_wr_i, reg_rd_i;
   logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o, q;
   logic [2:0] ref_input_load_select_o, feedback_input_load_select_o;
   logic bypass_short_delay_o;
   logic [75:0] output_drive_code_o;
   int mismatches = 0;
   int comparisons = 0;
   logic [7:0] pos [6] = '{8'hDE, 8'hD8, 8'hDD, 8'h91, 8'h92, 8'hD7};
   wire logic [82:0] img = {bypass_short_delay_o, feedback_input_load_select_o,
      ref_input_load_select_o, output_drive_code_o};
   ifb_feature_store u_ifb_feature_store (.*);
   ifb_host u_ifb_host (.clock_i(clock_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
      .rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
   // Clock at 200 MHz.
   initial begin
      clock_i = 1'h0;
      forever #2.5 clock_i = ~clock_i;
   end
   task automatic check(input string n, input logic [83:0] s, input logic [83:0] e);
      comparisons++;
      if (s !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic tally_and_finish();
      $display("%0d comparisons, %0d mismatches", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // The sequence needs well under a microsecond, so a hang is cut short here.
   initial begin
      #20000;
      mismatches++;
      tally_and_finish();
   end
   // Bit 215 stays set until the second reset; bits 145 and 146 make output 1 code 0110.
   initial begin
      rst_b_i = 1'h0;
      repeat (5) @(posedge clock_i);
      #1 rst_b_i = 1'h1;
      check("reset", 84'(img), 84'h0);
      u_ifb_host.xfer(1'h1, 8'h09, 8'hDE, q);
      u_ifb_host.xfer(1'h1, 8'h0A, 8'h82, q);
      check("locked", 84'(img), 84'h0);
      $display("Reset and lock test done.");
      u_ifb_host.xfer(1'h1, 8'h08, 8'hBB, q);
      foreach (pos[i]) u_ifb_host.set_bit(pos[i], 1'h1);
      check("fields", 84'(img), 84'h6_1_8000000000000000060);
      u_ifb_host.xfer(1'h1, 8'h09, 8'h92, q);
      u_ifb_host.xfer(1'h0, 8'h0A, 8'h00, q);
      check("bit six", 84'(q), 84'h40);
      u_ifb_host.xfer(1'h0, 8'h09, 8'h00, q);
      check("pointer", 84'(q), 84'h92);
      u_ifb_host.xfer(1'h0, 8'h08, 8'h00, q);
      check("unlock", 84'(q), 84'hBB);
      u_ifb_host.xfer(1'h1, 8'h0A, 8'h80, q);
      u_ifb_host.xfer(1'h0, 8'h0A, 8'h00, q);
      check("clear", {q, img[75:0]}, {8'h80, 76'h8000000000000000020});
      u_ifb_host.xfer(1'h1, 8'h0A, 8'h00, q);
      $display("Field write test done.");
      u_ifb_host.xfer(1'h1, 8'h08, 8'h55, q);
      u_ifb_host.set_bit(8'hD7, 1'h0);
      u_ifb_host.xfer(1'h0, 8'h0B, 8'h00, q);
      check("relocked", {q, img[75:0]}, {8'h00, 76'h8000000000000000020});
      $display("Relock test done.");
      rst_b_i = 1'h0;
      @(posedge clock_i);
      #1 rst_b_i = 1'h1;
      check("reset again", 84'(img), 84'h0);
      $display("Second reset test done.");
      tally_and_finish();
   end
endmodule
`default_nettype wire
